// ### lin_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// single wire with pull-up: any node pulling low makes it dominant
module lin_bus_model (
    input wire logic drv_i,
    input wire logic drv_oe_i,
    input wire logic remote_dom_i,
    output wire logic bus_o
);
assign bus_o = !((drv_oe_i && !drv_i) || remote_dom_i);
endmodule // lin_bus_model
`default_nettype wire

// ### lin_channel_map.vh
`ifndef LIN_CHANNEL_MAP_VH
`define LIN_CHANNEL_MAP_VH
// clock rate
`define CLK_HZ 20000000
`define CLK_MHZ 20
// mode codes
`define MODE_SLEEP 2'h0
`define MODE_NORMAL 2'h1
`define MODE_STANDBY 2'h2
// times in their own unit, as printed
`define WAKE_FILTER_US_MIN 40
`define WAKE_FILTER_US_MAX 150
`define WAKE_FILTER_US_TYP 70
`define DOM_TIMEOUT_MS_MIN 14
`define DOM_TIMEOUT_MS_MAX 46
`define DOM_TIMEOUT_MS_TYP 25
`define STARTUP_US_MIN 15
`define STARTUP_US_MAX 75
`define STARTUP_US_TYP 30
`define EN_FILTER_US_MIN 11
`define EN_FILTER_US_MAX 55
`define EN_FILTER_US_TYP 20
`define STBY_DELAY_NS_MIN 5000
`define STBY_DELAY_NS_MAX 40000
`define STBY_DELAY_NS_TYP 10000
// cycle counts at 20 MHz, typical points, all inside the windows
// sized to the counter width so no connection drops bits
`define CNT_W 20
`define WAKE_FILTER_CYC 20'h00578
`define STARTUP_CYC 20'h00258
`define EN_FILTER_CYC 20'h00190
`define STBY_DELAY_CYC 20'h000c8
`define DOM_TIMEOUT_CYC 20'h7a120
`endif

// ### lin_channel_mode_timers.v
// Function
// - in sleep, wake only after bus dominant continuously for the wake filter
// - in normal, transmit low past the timeout releases driver recessive
// - transmitter usable only after startup time from enable rising edge
// - enter normal only after enable high for the filter time
// - enter sleep only after enable low for the filter time
// - after valid wake, enter standby a delay after next recessive edge
`timescale 1ns/1ps
`default_nettype none
`include "lin_channel_map.vh"
module lin_channel_mode_timers #(
    parameter [`CNT_W-1:0] DOM_TIMEOUT_CYC = `DOM_TIMEOUT_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire transmit_in_i,
    input wire channel_enable_in_i,
    input wire bus_line_i,
    output wire bus_line_o,
    output wire bus_line_oe_o,
    output wire receive_out_o,
    output wire receive_out_oe_o,
    output wire [1:0] mode_o,
    output wire tx_ready_o,
    output wire timeout_o
);
    localparam [`CNT_W-1:0] EN_LIM = `EN_FILTER_CYC;
    localparam [`CNT_W-1:0] WAKE_LIM = `WAKE_FILTER_CYC;
    localparam [`CNT_W-1:0] START_LIM = `STARTUP_CYC;
    localparam [`CNT_W-1:0] STBY_LIM = `STBY_DELAY_CYC;
    localparam [1:0] ST_SLEEP = `MODE_SLEEP;
    localparam [1:0] ST_NORMAL = `MODE_NORMAL;
    localparam [1:0] ST_STANDBY = `MODE_STANDBY;

    ////////////////////////////////////////////////////////////////////
    reg [1:0] mode_ff;
    reg [1:0] nxt_mode;
    reg wake_ff;
    reg nxt_wake;
    reg en_q_ff;
    reg start_run_ff;
    reg to_ff;
    reg nxt_to;
    reg [`CNT_W-1:0] stby_cnt_ff;
    reg [`CNT_W-1:0] nxt_stby_cnt;
    reg stby_run_ff;
    reg nxt_stby_run;
    reg bus_q_ff;
    wire en_hi_done;
    wire en_lo_done;
    wire wake_done;
    wire start_done;
    wire to_done;
    wire bus_dom;
    wire rec_edge;

    assign bus_dom = !bus_line_i;
    assign rec_edge = !bus_q_ff && bus_line_i;

    ////////////////////////////////////////////////////////////////////
    // one generate loop for the two enable filters, high and low
    wire [1:0] en_run;
    wire [1:0] en_done;
    assign en_run = {!channel_enable_in_i, channel_enable_in_i};
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_en_filt
            lin_hold_timer u_filt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .run_i(en_run[g]),
                .limit_i(EN_LIM),
                .done_o(en_done[g])
            );
        end
    endgenerate
    assign en_hi_done = en_done[0];
    assign en_lo_done = en_done[1];

    // wake filter restarts on any recessive sample
    lin_hold_timer u_wake (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(bus_dom && (mode_ff == ST_SLEEP) && !wake_ff),
        .limit_i(WAKE_LIM),
        .done_o(wake_done)
    );

    // startup timer runs from an enable rising edge while enable stays high
    lin_hold_timer u_start (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(start_run_ff && channel_enable_in_i),
        .limit_i(START_LIM),
        .done_o(start_done)
    );

    // dominant timeout; held at zero once fired until transmit returns high
    lin_hold_timer u_to (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(!transmit_in_i && (mode_ff == ST_NORMAL) && !to_ff),
        .limit_i(DOM_TIMEOUT_CYC),
        .done_o(to_done)
    );

    ////////////////////////////////////////////////////////////////////
    always @* begin
        nxt_mode = mode_ff;
        nxt_wake = wake_ff;
        nxt_stby_run = stby_run_ff;
        nxt_stby_cnt = stby_cnt_ff;
        nxt_to = to_ff;
        case (mode_ff)
            ST_SLEEP: begin
                if (en_hi_done) begin
                    nxt_mode = ST_NORMAL;
                    nxt_wake = 1'b0;
                    nxt_stby_run = 1'b0;
                end else begin
                    if (wake_done) begin
                        nxt_wake = 1'b1;
                    end
                    if (wake_ff && rec_edge) begin
                        nxt_stby_run = 1'b1;
                        nxt_stby_cnt = {`CNT_W{1'b0}};
                    end else if (stby_run_ff) begin
                        if (stby_cnt_ff == STBY_LIM) begin
                            nxt_mode = ST_STANDBY;
                            nxt_stby_run = 1'b0;
                            nxt_wake = 1'b0;
                        end else begin
                            nxt_stby_cnt = stby_cnt_ff + 1'b1;
                        end
                    end
                end
            end
            ST_STANDBY: begin
                if (en_hi_done) begin
                    nxt_mode = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (en_lo_done) begin
                    nxt_mode = ST_SLEEP;
                    nxt_to = 1'b0;
                end
            end
            default: begin
                nxt_mode = ST_SLEEP;
            end
        endcase
        // leaving normal clears the flag, even on the firing cycle
        if ((mode_ff == ST_NORMAL) && !en_lo_done) begin
            if (to_done) begin
                nxt_to = 1'b1;
            end else if (to_ff && transmit_in_i) begin
                nxt_to = 1'b0;
            end
        end
    end

    // mode and wake state
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_ff <= ST_SLEEP;
            wake_ff <= 1'b0;
            stby_run_ff <= 1'b0;
            stby_cnt_ff <= {`CNT_W{1'b0}};
        end else if (ce_i) begin
            mode_ff <= nxt_mode;
            wake_ff <= nxt_wake;
            stby_run_ff <= nxt_stby_run;
            stby_cnt_ff <= nxt_stby_cnt;
        end
    end

    // timeout flag; its drop re-arms the counter on the next edge
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            to_ff <= 1'b0;
        end else if (ce_i) begin
            to_ff <= nxt_to;
        end
    end

    // bus history resets recessive so no false edge follows reset
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_q_ff <= 1'b1;
        end else if (ce_i) begin
            bus_q_ff <= bus_line_i;
        end
    end

    // enable history resets low, the idle level of the pin
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_q_ff <= 1'b0;
            start_run_ff <= 1'b0;
        end else if (ce_i) begin
            en_q_ff <= channel_enable_in_i;
            // restart on each rising edge, drop when enable falls
            if (channel_enable_in_i && !en_q_ff) begin
                start_run_ff <= 1'b1;
            end else if (!channel_enable_in_i) begin
                start_run_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // driver only in normal, after startup, and never while timed out
    assign tx_ready_o = (mode_ff == ST_NORMAL) && start_done;
    assign bus_line_o = 1'b0;
    assign bus_line_oe_o = tx_ready_o && !transmit_in_i && !to_ff;
    // receive open-drain pulls low on dominant bus
    assign receive_out_o = 1'b0;
    assign receive_out_oe_o = bus_dom;
    assign mode_o = mode_ff;
    assign timeout_o = to_ff;
endmodule // lin_channel_mode_timers
`default_nettype wire

// ### lin_hold_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "lin_channel_map.vh"
// counts cycles while run_i is high; done_o once the limit is reached
module lin_hold_timer (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire run_i,
    input wire [`CNT_W-1:0] limit_i,
    output wire done_o
);
    reg [`CNT_W-1:0] cnt_ff;
    wire [`CNT_W-1:0] nxt_cnt;
    // saturates so done stays up while run holds
    assign nxt_cnt = !run_i ? {`CNT_W{1'b0}} :
                     (cnt_ff == limit_i) ? cnt_ff : cnt_ff + 1'b1;
    assign done_o = run_i && (cnt_ff == limit_i);
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= {`CNT_W{1'b0}};
        end else if (ce_i) begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // lin_hold_timer
`default_nettype wire

// ### lin_mode_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "lin_channel_map.vh"
module lin_mode_props #(
    parameter [`CNT_W-1:0] DOM_TIMEOUT_CYC = `DOM_TIMEOUT_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire transmit_in_i,
    input wire channel_enable_in_i,
    input wire bus_line_i,
    input wire bus_line_o,
    input wire bus_line_oe_o,
    input wire receive_out_o,
    input wire receive_out_oe_o,
    input wire [1:0] mode_o,
    input wire tx_ready_o,
    input wire timeout_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
////////////////////////////////////////////////////////////////
// run lengths of each level, saturating so long idles never wrap
logic [15:0] hi_ff, lo_ff, dom_ff, rec_ff, last_dom_ff;
// as wide as the design's counter so the full timeout never wraps
logic [`CNT_W-1:0] txl_ff;
always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        hi_ff <= 16'h0;
        lo_ff <= 16'h0;
        dom_ff <= 16'h0;
        rec_ff <= 16'h0;
        last_dom_ff <= 16'h0;
        txl_ff <= {`CNT_W{1'b0}};
    end else if (ce_i) begin
        hi_ff <= channel_enable_in_i ? hi_ff + {15'h0, hi_ff != 16'hffff} : 16'h0;
        lo_ff <= !channel_enable_in_i ? lo_ff + {15'h0, lo_ff != 16'hffff} : 16'h0;
        dom_ff <= !bus_line_i ? dom_ff + {15'h0, dom_ff != 16'hffff} : 16'h0;
        rec_ff <= bus_line_i ? rec_ff + {15'h0, rec_ff != 16'hffff} : 16'h0;
        if (bus_line_i && dom_ff != 16'h0) begin
            last_dom_ff <= dom_ff;
        end
        txl_ff <= (!transmit_in_i && mode_o == `MODE_NORMAL) ?
            txl_ff + {{(`CNT_W-1){1'b0}}, ~&txl_ff} : {`CNT_W{1'b0}};
    end
end
////////////////////////////////////////////////////////////////
sequence s_enter(m);
    $past(mode_o) != m && mode_o == m;
endsequence
sequence s_to_stby;
    $past(mode_o) == `MODE_SLEEP && mode_o == `MODE_STANDBY;
endsequence
normal_entry_a: assert property (s_enter(`MODE_NORMAL) |-> hi_ff >= 220 && hi_ff <= 1100)
    else $error("normal mode entered outside enable filter window");
sleep_entry_a: assert property (s_enter(`MODE_SLEEP) |-> lo_ff >= 220 && lo_ff <= 1100)
    else $error("sleep mode entered outside disable filter window");
wake_filter_a: assert property (s_to_stby |-> last_dom_ff >= 800)
    else $error("standby after a dominant shorter than the wake filter");
stby_delay_a: assert property (s_to_stby |-> rec_ff >= 100 && rec_ff <= 800)
    else $error("standby entry delay out of window");
startup_a: assert property ($rose(tx_ready_o) |-> hi_ff >= 300 && hi_ff <= 1500)
    else $error("transmitter ready outside startup window");
ready_mode_a: assert property (tx_ready_o |-> mode_o == `MODE_NORMAL)
    else $error("transmitter ready outside normal mode");
timeout_fire_a: assert property ($rose(timeout_o) |-> txl_ff + 2 >= DOM_TIMEOUT_CYC
    && txl_ff <= DOM_TIMEOUT_CYC + 2)
    else $error("dominant timeout at wrong count");
timeout_rel_a: assert property (timeout_o |-> !bus_line_oe_o)
    else $error("driver active after dominant timeout");
rearm_a: assert property (timeout_o && transmit_in_i |=> !timeout_o)
    else $error("timeout not cleared by recessive transmit");
endmodule // lin_mode_props
`default_nettype wire

// ### test_lin_channel_mode_timers.sv
`timescale 1ns/1ps
`default_nettype none
`include "lin_channel_map.vh"
module test_lin_channel_mode_timers;
localparam [`CNT_W-1:0] DOM = 20'h00032;
logic clk_i = 0, rst_i = 1, tx = 1, en = 0, remote = 0, ce = 1;
wire logic bus, bus_o, oe, rx_o, rx_oe, rdy, tmo;
wire logic [1:0] mode;
integer n_fail = 0, checked = 0, n, k;
initial begin
    forever #25 clk_i = ~clk_i;
end
lin_channel_mode_timers #(.DOM_TIMEOUT_CYC(DOM)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .transmit_in_i(tx), .channel_enable_in_i(en), .bus_line_i(bus), .bus_line_o(bus_o),
    .bus_line_oe_o(oe), .receive_out_o(rx_o), .receive_out_oe_o(rx_oe), .mode_o(mode),
    .tx_ready_o(rdy), .timeout_o(tmo));
lin_bus_model bus_m (.drv_i(bus_o), .drv_oe_i(oe), .remote_dom_i(remote), .bus_o(bus));
////////////////////////////////////////////////////////////////
task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
        n_fail++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task end_of_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task cyc(input integer c);
    repeat (c) @(negedge clk_i);
endtask
task wait_mode(input logic [1:0] m, input integer lim);
    n = 0;
    while (mode !== m) begin
        if (n >= lim) begin
            n_fail++;
            end_of_test;
        end
        cyc(1);
        n++;
    end
endtask
////////////////////////////////////////////////////////////////
task t_enable;
    en = 1; cyc(200); en = 0; cyc(20);
    chk(mode, `MODE_SLEEP);
    en = 1; wait_mode(`MODE_NORMAL, 1200);
    chk(n >= 220 && n <= 1101, 1);
    k = n;
    while (rdy !== 1'b1) begin
        if (k >= 1600) begin
            n_fail++;
            end_of_test;
        end
        cyc(1);
        k++;
    end
    chk(k >= 300 && k <= 1501, 1);
endtask
task t_timeout;
    tx = 0; #1;
    chk({oe, bus, rx_oe, bus_o, rx_o}, 5'h14);
    cyc(DOM - 5);
    chk(tmo, 0);
    cyc(10);
    chk({tmo, oe}, 2'h2);
    tx = 1; cyc(2);
    chk(tmo, 0);
    tx = 0; #1;
    chk(oe, 1);
    // re-armed count must run its full length again
    cyc(DOM - 5);
    chk(tmo, 0);
    // clock enable low freezes the count
    ce = 0; cyc(20); ce = 1;
    chk(tmo, 0);
    cyc(10);
    chk({tmo, oe}, 2'h2);
    tx = 1; cyc(2);
    chk(tmo, 0);
endtask
task t_sleep;
    en = 0; cyc(200); en = 1; cyc(20);
    chk(mode, `MODE_NORMAL);
    en = 0; wait_mode(`MODE_SLEEP, 1200);
    chk(n >= 220 && n <= 1101, 1);
endtask
task t_wake;
    // below 40 us of dominant must never wake
    remote = 1; cyc(700); remote = 0; cyc(300);
    chk({mode, rx_oe}, 3'h0);
    // past the longest wake filter
    remote = 1; cyc(3100); remote = 0; cyc(90);
    chk(mode, `MODE_SLEEP);
    wait_mode(`MODE_STANDBY, 720);
    chk(n + 90 >= 100 && n + 90 <= 801, 1);
    en = 1; wait_mode(`MODE_NORMAL, 1200);
    chk(n >= 220 && n <= 1101, 1);
    rst_i = 1; cyc(2);
    chk({mode, rdy, tmo, oe}, 5'h0);
    rst_i = 0; cyc(2);
    chk(mode, `MODE_SLEEP);
endtask
initial begin
    cyc(8);
    rst_i = 0;
    cyc(2);
    t_enable;
    t_timeout;
    t_sleep;
    t_wake;
    end_of_test;
end
endmodule // test_lin_channel_mode_timers
bind lin_channel_mode_timers lin_mode_props #(.DOM_TIMEOUT_CYC(DOM_TIMEOUT_CYC)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .transmit_in_i(transmit_in_i),
    .channel_enable_in_i(channel_enable_in_i), .bus_line_i(bus_line_i), .bus_line_o(bus_line_o),
    .bus_line_oe_o(bus_line_oe_o), .receive_out_o(receive_out_o),
    .receive_out_oe_o(receive_out_oe_o), .mode_o(mode_o), .tx_ready_o(tx_ready_o),
    .timeout_o(timeout_o));
`default_nettype wire
